// ### shared/ec_core_regs.svh
// Register offsets, field positions, reset values and codes of the core integration block
`ifndef EC_CORE_REGS_SVH
`define EC_CORE_REGS_SVH

`define REG_STATUS      8'h00
`define REG_STATE       8'h04
`define REG_EPC         8'h08
`define REG_DEPC        8'h0c
`define REG_EBASE       8'h10
`define REG_CMD         8'h14
`define REG_ARG         8'h18
`define REG_MULB        8'h1c
`define REG_HI          8'h20
`define REG_LO          8'h24
`define REG_PC          8'h28
`define REG_BRK_EN      8'h2c
`define REG_IBRK_PAGE   4'h3
`define REG_DBRK_PAGE   5'h08

`define ST_IE           0
`define ST_EXC_LEVEL    1
`define ST_ERR_LEVEL    2
`define ST_LOW_POWER    27
`define ST_IPL_LSB      10
`define ST_IPL_MSB      15

`define BOOT_ADDR       32'hbfc00000
`define DEBUG_VECTOR    32'hbfc00480
`define EBASE_RESET     32'hbfd00000
`define EXC_OFFSET      32'h00000180
`define DRAM_BASE       32'hbfd18000

`define OP_NOP          4'h0
`define OP_WAIT         4'h1
`define OP_EXC_RETURN   4'h2
`define OP_DERET        4'h3
`define OP_JUMP         4'h4
`define OP_LOAD         4'h5
`define OP_MUL          4'h6

`define EXC_INT         5'h00
`define EXC_RI          5'h0a
`define EXC_RESET       5'h1e
`define EXC_DEBUG       5'h1f

`define NUM_IBRK        4
`define NUM_DBRK        2
`define NUM_GPR         32

`endif

// ### shared/ec_core_pkg.sv
// Types shared by the core integration block
package ec_core_pkg;
    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_MUL
    } core_state_type;
endpackage

// ### logic/ec_core_sysif.sv
// Core integration block: system status outputs, memory ports, exceptions, sleep and debug
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`include "ec_core_regs.svh"

module ec_core_sysif (
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic [7:0]  address_in,
    input  wire logic        read_in,
    input  wire logic        write_in,
    input  wire logic [31:0] writedata_in,
    input  wire logic [3:0]  byteenable_in,
    output logic      [31:0] readdata_out,
    output logic             waitrequest_out,
    input  wire logic        soft_reset_in,
    input  wire logic        cold_reset_input_in,
    input  wire logic        debug_probe_cmd_in,
    input  wire logic        irq_req_in,
    input  wire logic [5:0]  irq_level_in,
    input  wire logic [15:0] irq_vector_in,
    output logic             reduced_power_status_out,
    output logic             exception_level_status_out,
    output logic             error_level_status_out,
    output logic             debug_mode_indicator_out,
    output logic             sleep_out,
    output logic             ifetch_en_out,
    output logic      [31:0] ifetch_addr_out,
    output logic             ifetch_dmem_out,
    output logic             dacc_en_out,
    output logic      [31:0] dacc_addr_out,
    output logic             dacc_dmem_out
);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic is_data_mem(input logic [31:0] addr);
        is_data_mem = (addr >= `DRAM_BASE);
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        merge_be = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                merge_be[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
    endfunction

    function automatic logic op_supported(input logic [3:0] op);
        op_supported = (op <= `OP_MUL);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then the access completes
    logic        wait_q;
    logic [31:0] rdata_q;
    logic [31:0] rd_d;
    logic        bus_req;
    logic        wr_en;

    assign bus_req = read_in | write_in;
    assign wr_en   = write_in & ~wait_q;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q <= ~(bus_req & wait_q);
            if (read_in && wait_q) begin
                rdata_q <= rd_d;
            end
        end
    end

    assign waitrequest_out = wait_q;
    assign readdata_out    = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the edge detector only looks at the second and third stages
    logic [1:0] soft_s_q;
    logic [1:0] cold_s_q;
    logic [2:0] dbg_s_q;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            soft_s_q <= 2'h0;
            cold_s_q <= 2'h0;
            dbg_s_q  <= 3'h0;
        end else begin
            soft_s_q <= {soft_s_q[0], soft_reset_in};
            cold_s_q <= {cold_s_q[0], cold_reset_input_in};
            dbg_s_q  <= {dbg_s_q[1:0], debug_probe_cmd_in};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core state
    ec_core_pkg::core_state_type state_q;
    logic [31:0] pc_q;
    logic [31:0] epc_q;
    logic [31:0] depc_q;
    logic [31:0] ebase_q;
    logic [31:0] arg_q;
    logic [31:0] mulb_q;
    logic        ie_q;
    logic        exc_level_q;
    logic        err_level_q;
    logic        low_power_q;
    logic [5:0]  ipl_q;
    logic        debug_q;
    logic        sleep_q;
    logic        mem_en_q;
    logic [4:0]  exc_q;
    logic [63:0] acc_q;
    logic        mul_phase_q;
    logic [5:0]  brk_en_q;
    logic [31:0] ibrk_q [`NUM_IBRK];
    logic [31:0] dbrk_q [`NUM_DBRK];
    logic [31:0] gpr_q  [`NUM_GPR];

    logic        reset_exc;
    logic        cmd_go;
    logic [3:0]  cmd_op;
    logic        brk_hit;
    logic        dbg_req;
    logic        int_ok;
    logic        cmd_ok;
    logic        status_wr;
    logic [`NUM_IBRK-1:0] ihit;
    logic [`NUM_DBRK-1:0] dhit;

    assign reset_exc = soft_s_q[1] | cold_s_q[1];
    assign cmd_go    = wr_en && address_in == `REG_CMD;
    assign cmd_op    = writedata_in[3:0];
    assign status_wr = wr_en && address_in == `REG_STATUS;
    // Only the external controller can interrupt; nothing here is unmaskable
    assign int_ok    = irq_req_in && ie_q && !exc_level_q && !err_level_q && !debug_q
                       && irq_level_in > ipl_q;
    assign dbg_req   = ((dbg_s_q[1] & ~dbg_s_q[2]) | brk_hit) && !debug_q;
    assign cmd_ok    = cmd_go && !reset_exc && !dbg_req && state_q == ec_core_pkg::ST_RUN;

    // Breakpoints are plain address matches taken at a command boundary
    genvar gi;
    generate
        for (gi = 0; gi < `NUM_IBRK; gi++) begin : g_ibrk
            assign ihit[gi] = brk_en_q[gi] && cmd_go && pc_q == ibrk_q[gi];
        end
        for (gi = 0; gi < `NUM_DBRK; gi++) begin : g_dbrk
            assign dhit[gi] = brk_en_q[`NUM_IBRK + gi] && cmd_go && cmd_op == `OP_LOAD
                              && arg_q == dbrk_q[gi];
        end
    endgenerate
    assign brk_hit = |ihit | |dhit;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q  <= ec_core_pkg::ST_RUN;
            pc_q     <= `BOOT_ADDR;
            epc_q    <= 32'h00000000;
            depc_q   <= 32'h00000000;
            ie_q        <= 1'b0;
            exc_level_q <= 1'b0;
            err_level_q <= 1'b1;
            low_power_q <= 1'b0;
            ipl_q    <= 6'h00;
            debug_q  <= 1'b0;
            sleep_q  <= 1'b0;
            mem_en_q <= 1'b0;
            exc_q    <= `EXC_RESET;
        end else begin
            mem_en_q <= 1'b1;
            sleep_q  <= 1'b0;
            // Reduced-power bit is status only; it never puts the core to sleep
            if (status_wr) begin
                ie_q        <= writedata_in[`ST_IE];
                exc_level_q <= writedata_in[`ST_EXC_LEVEL];
                err_level_q <= writedata_in[`ST_ERR_LEVEL];
                low_power_q <= writedata_in[`ST_LOW_POWER];
                ipl_q <= writedata_in[`ST_IPL_MSB:`ST_IPL_LSB];
            end
            // Hardware events below override a same-cycle software write
            if (reset_exc) begin
                epc_q   <= pc_q;
                pc_q    <= `BOOT_ADDR;
                err_level_q <= 1'b1;
                ie_q        <= 1'b0;
                low_power_q <= 1'b0;
                debug_q <= 1'b0;
                state_q <= ec_core_pkg::ST_RUN;
                exc_q   <= `EXC_RESET;
            end else if (dbg_req) begin
                depc_q  <= pc_q;
                pc_q    <= `DEBUG_VECTOR;
                debug_q <= 1'b1;
                state_q <= ec_core_pkg::ST_RUN;
                exc_q   <= `EXC_DEBUG;
            end else if (state_q == ec_core_pkg::ST_SLEEP) begin
                if (irq_req_in) begin
                    state_q <= ec_core_pkg::ST_RUN;
                    if (int_ok) begin
                        epc_q       <= pc_q + 32'h4;
                        exc_level_q <= 1'b1;
                        ipl_q <= irq_level_in;
                        pc_q  <= ebase_q + {16'h0000, irq_vector_in};
                        exc_q <= `EXC_INT;
                    end else begin
                        pc_q <= pc_q + 32'h4;
                    end
                end else begin
                    mem_en_q <= 1'b0;
                    sleep_q  <= 1'b1;
                end
            end else if (state_q == ec_core_pkg::ST_MUL) begin
                state_q <= ec_core_pkg::ST_RUN;
                pc_q    <= pc_q + 32'h4;
            end else if (cmd_ok) begin
                if (!op_supported(cmd_op) || (cmd_op == `OP_DERET && !debug_q)) begin
                    epc_q       <= pc_q;
                    exc_level_q <= 1'b1;
                    pc_q  <= ebase_q + `EXC_OFFSET;
                    exc_q <= `EXC_RI;
                end else begin
                    unique case (cmd_op)
                        `OP_WAIT: begin
                            state_q  <= ec_core_pkg::ST_SLEEP;
                            sleep_q  <= 1'b1;
                            mem_en_q <= 1'b0;
                        end
                        `OP_EXC_RETURN: begin
                            pc_q <= epc_q;
                            if (err_level_q) begin
                                err_level_q <= 1'b0;
                            end else begin
                                exc_level_q <= 1'b0;
                            end
                        end
                        `OP_DERET: begin
                            pc_q    <= depc_q;
                            debug_q <= 1'b0;
                        end
                        `OP_JUMP: begin
                            pc_q <= arg_q;
                        end
                        `OP_MUL: begin
                            state_q <= ec_core_pkg::ST_MUL;
                        end
                        default: begin
                            pc_q <= pc_q + 32'h4;
                        end
                    endcase
                end
            end else if (int_ok && state_q == ec_core_pkg::ST_RUN) begin
                epc_q       <= pc_q;
                exc_level_q <= 1'b1;
                ipl_q <= irq_level_in;
                pc_q  <= ebase_q + {16'h0000, irq_vector_in};
                exc_q <= `EXC_INT;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software-written configuration and operands
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ebase_q  <= `EBASE_RESET;
            arg_q    <= 32'h00000000;
            mulb_q   <= 32'h00000000;
            brk_en_q <= 6'h00;
        end else if (wr_en) begin
            if (address_in == `REG_EBASE) begin
                ebase_q <= merge_be(ebase_q, writedata_in, byteenable_in);
            end
            if (address_in == `REG_ARG) begin
                arg_q <= merge_be(arg_q, writedata_in, byteenable_in);
            end
            if (address_in == `REG_MULB) begin
                mulb_q <= merge_be(mulb_q, writedata_in, byteenable_in);
            end
            if (address_in == `REG_BRK_EN) begin
                brk_en_q <= writedata_in[5:0];
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (wr_en && address_in[7:4] == `REG_IBRK_PAGE) begin
            ibrk_q[address_in[3:2]] <= merge_be(ibrk_q[address_in[3:2]], writedata_in, byteenable_in);
        end
        if (wr_en && address_in[7:3] == `REG_DBRK_PAGE) begin
            dbrk_q[address_in[2]] <= merge_be(dbrk_q[address_in[2]], writedata_in, byteenable_in);
        end
        // Single register set; entry zero is never stored
        if (wr_en && address_in[7] && address_in[6:2] != 5'h00) begin
            gpr_q[address_in[6:2]] <= merge_be(gpr_q[address_in[6:2]], writedata_in, byteenable_in);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // 32x16 array: a full 32x32 product takes two passes
    logic [47:0] part_d;

    assign part_d = arg_q * (mul_phase_q ? mulb_q[31:16] : mulb_q[15:0]);

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc_q       <= 64'h0000000000000000;
            mul_phase_q <= 1'b0;
        end else if (cmd_ok && cmd_op == `OP_MUL) begin
            acc_q       <= {16'h0000, part_d};
            mul_phase_q <= 1'b1;
        end else if (mul_phase_q) begin
            acc_q       <= acc_q + {part_d, 16'h0000};
            mul_phase_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory ports; the fetch enable follows the core one cycle late, the data enable is registered on the same edge as the load
    logic        if_en_q;
    logic [31:0] if_addr_q;
    logic        if_dmem_q;
    logic        da_en_q;
    logic [31:0] da_addr_q;
    logic        da_dmem_q;

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            if_en_q   <= 1'b0;
            if_addr_q <= `BOOT_ADDR;
            if_dmem_q <= 1'b0;
            da_en_q   <= 1'b0;
            da_addr_q <= 32'h00000000;
            da_dmem_q <= 1'b0;
        end else begin
            if_en_q   <= mem_en_q;
            if_addr_q <= pc_q;
            if_dmem_q <= is_data_mem(pc_q);
            da_en_q   <= cmd_ok && cmd_op == `OP_LOAD;
            if (cmd_ok && cmd_op == `OP_LOAD) begin
                da_addr_q <= arg_q;
                da_dmem_q <= is_data_mem(arg_q);
            end
        end
    end

    assign ifetch_en_out   = if_en_q;
    assign ifetch_addr_out = if_addr_q;
    assign ifetch_dmem_out = if_dmem_q;
    assign dacc_en_out     = da_en_q;
    assign dacc_addr_out   = da_addr_q;
    assign dacc_dmem_out   = da_dmem_q;

    assign reduced_power_status_out   = low_power_q;
    assign exception_level_status_out = exc_level_q;
    assign error_level_status_out     = err_level_q;
    assign debug_mode_indicator_out   = debug_q;
    assign sleep_out                  = sleep_q;

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        rd_d = 32'h00000000;
        if (address_in[7]) begin
            rd_d = (address_in[6:2] == 5'h00) ? 32'h00000000 : gpr_q[address_in[6:2]];
        end else if (address_in[7:4] == `REG_IBRK_PAGE) begin
            rd_d = ibrk_q[address_in[3:2]];
        end else if (address_in[7:3] == `REG_DBRK_PAGE) begin
            rd_d = dbrk_q[address_in[2]];
        end else begin
            unique case (address_in)
                `REG_STATUS: begin
                    rd_d[`ST_IE]                  = ie_q;
                    rd_d[`ST_EXC_LEVEL]           = exc_level_q;
                    rd_d[`ST_ERR_LEVEL]           = err_level_q;
                    rd_d[`ST_LOW_POWER]           = low_power_q;
                    rd_d[`ST_IPL_MSB:`ST_IPL_LSB] = ipl_q;
                end
                `REG_STATE:  rd_d = {16'h0000, irq_level_in, 3'h0, exc_q, debug_q, sleep_q};
                `REG_EPC:    rd_d = epc_q;
                `REG_DEPC:   rd_d = depc_q;
                `REG_EBASE:  rd_d = ebase_q;
                `REG_CMD:    rd_d = {31'h00000000, state_q != ec_core_pkg::ST_RUN};
                `REG_ARG:    rd_d = arg_q;
                `REG_MULB:   rd_d = mulb_q;
                `REG_HI:     rd_d = acc_q[63:32];
                `REG_LO:     rd_d = acc_q[31:0];
                `REG_PC:     rd_d = pc_q;
                `REG_BRK_EN: rd_d = {26'h0000000, brk_en_q};
                default:     rd_d = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    low_power_write_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        status_wr && !reset_exc |=> reduced_power_status_out == $past(writedata_in[`ST_LOW_POWER]))
        else $error("reduced-power output does not follow status write");

    ri_sets_level_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cmd_ok && !op_supported(cmd_op) |=> exception_level_status_out && pc_q == ebase_q + `EXC_OFFSET)
        else $error("unsupported op did not raise exception level");

    reset_exc_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        reset_exc |=> error_level_status_out && pc_q == `BOOT_ADDR && !debug_mode_indicator_out)
        else $error("reset exception not taken");

    debug_entry_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        dbg_req && !reset_exc |=> debug_mode_indicator_out && depc_q == $past(pc_q))
        else $error("debug exception not taken");

    sleep_frozen_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        sleep_q && !irq_req_in && !reset_exc && !dbg_req |=> $stable(pc_q) ##1 !ifetch_en_out)
        else $error("core changed state or memories enabled while asleep");

    wait_entry_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cmd_ok && cmd_op == `OP_WAIT |=> sleep_out ##1 !ifetch_en_out)
        else $error("wait did not enter sleep");

    exc_before_int_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cmd_ok && int_ok && cmd_op == `OP_NOP |=> pc_q == $past(pc_q) + 32'h4 && $stable(ipl_q))
        else $error("interrupt taken ahead of instruction");

    mul_result_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cmd_ok && cmd_op == `OP_MUL && !status_wr |-> ##2 acc_q == 64'(arg_q) * 64'(mulb_q))
        else $error("two-pass product wrong");

    load_port_a: assert property (@(posedge mclk_in) disable iff (!reset_n_in)
        cmd_ok && cmd_op == `OP_LOAD |=> dacc_en_out && dacc_addr_out == $past(arg_q))
        else $error("data port not driven by load");

endmodule

// ### sim/irq_model.sv
// Interrupt controller model: level request with priority and vector offset
module irq_model (
    input  wire logic        mclk_in,
    input  wire logic        raise_in,
    output logic             irq_req_out = 1'b0,
    output logic      [5:0]  irq_level_out = 6'h00,
    output logic      [15:0] irq_vector_out = 16'h0000
);
    timeunit 1ns;
    timeprecision 1ps;
    // Level triggered, own priority; held until the bench withdraws it
    always @(posedge mclk_in) begin
        irq_req_out <= raise_in;
        irq_level_out <= raise_in ? 6'h05 : 6'h00;
        irq_vector_out <= raise_in ? 16'h0200 : 16'h0000;
    end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the core integration block
`include "ec_core_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 1'b0, reset_n_in = 1'b0, read_in = 1'b0, write_in = 1'b0;
    logic [7:0]  address_in = 8'h00;
    logic [31:0] writedata_in = 32'h0, rd, pc0, readdata_out, ifetch_addr_out, dacc_addr_out;
    logic        soft_reset_in = 1'b0, debug_probe_cmd_in = 1'b0, raise = 1'b0, irq_req;
    logic        waitrequest_out, low_pwr, exc_lvl, err_lvl, dbg, sleep_out, ifetch_en_out, ifetch_dmem_out;
    logic        dacc_en_out, dacc_dmem_out;
    logic [5:0]  irq_level;
    logic [15:0] irq_vector;
    logic [34:0] rows [4] = '{{32'h08000000, 3'b100}, {32'h2, 3'b010}, {32'h4, 3'b001}, {32'h0, 3'b000}};
    int          err_count = 0, checks = 0, cyc = 0;
    always #12.5 mclk_in = ~mclk_in;
    irq_model irq_model_inst (.mclk_in, .raise_in(raise), .irq_req_out(irq_req), .irq_level_out(irq_level),
        .irq_vector_out(irq_vector));
    ec_core_sysif ec_core_sysif_inst (.mclk_in, .reset_n_in, .address_in, .read_in, .write_in, .writedata_in,
        .byteenable_in(4'hf), .readdata_out, .waitrequest_out, .soft_reset_in, .cold_reset_input_in(1'b0),
        .debug_probe_cmd_in, .irq_req_in(irq_req), .irq_level_in(irq_level), .irq_vector_in(irq_vector),
        .reduced_power_status_out(low_pwr), .exception_level_status_out(exc_lvl), .error_level_status_out(err_lvl),
        .debug_mode_indicator_out(dbg), .sleep_out, .ifetch_en_out, .ifetch_addr_out, .ifetch_dmem_out,
        .dacc_en_out, .dacc_addr_out, .dacc_dmem_out);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
        checks++;
        if (s !== e) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // Request is held until waitrequest is sampled low; one idle edge first avoids double drives
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
        int t;
        t = 0;
        @(posedge mclk_in);
        address_in <= a;
        writedata_in <= d;
        write_in <= w;
        read_in <= !w;
        do @(posedge mclk_in); while (waitrequest_out !== 1'b0 && ++t < 50);
        if (t >= 50) cmp("waitrequest", 0, 1);
        rd = readdata_out;
        write_in <= 1'b0;
        read_in <= 1'b0;
    endtask
    task automatic settle(int n, string tn);
        repeat (n) @(posedge mclk_in);
        #1 $display("test %0s done", tn);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge mclk_in) if (++cyc > 5000) begin
        err_count++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        settle(3, "reset");
        cmp("err_level", 1, err_lvl);
        cmp("boot", `BOOT_ADDR, ifetch_addr_out);
        foreach (rows[i]) begin
            bus(1, `REG_STATUS, rows[i][34:3]);
            settle(1, "status");
            cmp("status", rows[i][2:0], {low_pwr, exc_lvl, err_lvl});
        end
        bus(0, 8'h48, 0);
        cmp("unmapped", 0, rd);
        bus(1, `REG_ARG, `DRAM_BASE);
        bus(1, `REG_CMD, `OP_JUMP);
        settle(2, "jump");
        cmp("fetch_dmem", 1, ifetch_dmem_out);
        for (int m = 0; m < 2; m++) begin
            bus(1, `REG_ARG, m ? `DRAM_BASE : `BOOT_ADDR);
            bus(1, `REG_CMD, `OP_LOAD);
            #1 cmp("dacc", {m[0], 1'b1}, {dacc_dmem_out, dacc_en_out});
            cmp("dacc_addr", m ? `DRAM_BASE : `BOOT_ADDR, dacc_addr_out);
        end
        bus(1, `REG_ARG, 32'h12345678);
        bus(1, `REG_MULB, 32'h9abcdef0);
        bus(1, `REG_CMD, `OP_MUL);
        bus(0, `REG_HI, 0);
        cmp("mul_hi", 32'((64'h12345678 * 64'h9abcdef0) >> 32), rd);
        bus(0, `REG_LO, 0);
        cmp("mul_lo", 32'(64'h12345678 * 64'h9abcdef0), rd);
        bus(0, `REG_PC, 0);
        pc0 = rd;
        bus(1, `REG_CMD, `OP_NOP);
        bus(0, `REG_PC, 0);
        cmp("nop_pc", pc0 + 32'h4, rd);
        bus(1, `REG_CMD, `OP_WAIT);
        settle(2, "wait");
        cmp("asleep", 2'b10, {sleep_out, ifetch_en_out});
        raise <= 1'b1;
        settle(4, "wake");
        raise <= 1'b0;
        cmp("awake", 2'b01, {sleep_out, ifetch_en_out});
        for (int op = 7; op < 16; op++) begin
            bus(1, `REG_STATUS, 0);
            bus(1, `REG_CMD, op);
            settle(2, "reserved");
            cmp("reserved", 1, exc_lvl);
        end
        cmp("exc_vec", `EBASE_RESET + `EXC_OFFSET, ifetch_addr_out);
        bus(1, `REG_CMD, `OP_EXC_RETURN);
        settle(2, "exc_return");
        cmp("exc_return", 0, exc_lvl);
        debug_probe_cmd_in <= 1'b1;
        settle(5, "debug");
        cmp("debug", 1, dbg);
        soft_reset_in <= 1'b1;
        settle(5, "soft_reset");
        cmp("soft", 2'b10, {err_lvl, dbg});
        soft_reset_in <= 1'b0;
        summarize();
    end
endmodule
